// [hw/conv_pkg.sv]
// Behaviour
// - mid-range gives 10000000, one below 01111111
// - top reference and above saturate at 11111111
// - bottom reference and below give zeros
// - power-down input high enters low-consumption state
// - unconnected power-down input reads as low
// - data outputs high-impedance during power-down
// - receiver ignores samples taken during power-down
// - five words after power-down release are invalid
// - conversion clock stays at or below 30MSPS
// - clock near 50% duty at high rates
// - one sample processed per external clock
package conv_pkg;
    localparam int          DATA_W      = 8;
    localparam int          SAMPLE_W    = 12;
    localparam logic [7:0]  CODE_MID    = 8'h80;
    localparam logic [7:0]  CODE_MAX    = 8'hff;
    localparam logic [7:0]  CODE_MIN    = 8'h00;
    localparam logic [2:0]  INVALID_CNT = 3'h5;
    localparam int          PIPE_DEPTH  = 5;
    // words still in flight through the link sync path at the default divider
    localparam logic [2:0]  LINK_LAG    = 3'h2;
    localparam int          MAX_RATE_HZ = 30000000;
    localparam int          CLK_HZ      = 50000000;
    localparam int          DIV_MIN     = (CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
    localparam logic [3:0]  CLK_DIV     = 4'(DIV_MIN < 2 ? 2 : DIV_MIN);
endpackage : conv_pkg

// [hw/conv_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface conv_link_if;
    logic                          conv_clk;
    logic                          conv_clk_oe_n;
    logic                          power_down;
    logic                          power_down_oe_n;
    logic [conv_pkg::DATA_W-1:0]   data;
    logic                          data_oe_n;
    modport device (input conv_clk, input conv_clk_oe_n, input power_down,
                    input power_down_oe_n, output data, output data_oe_n);
    modport capture (output conv_clk, output conv_clk_oe_n, output power_down,
                     output power_down_oe_n, input data, input data_oe_n);
endinterface : conv_link_if
`default_nettype wire

// [hw/conv_device.sv]
`timescale 1ns/10ps
`default_nettype none
module conv_device #(
    parameter int SAMPLE_W = conv_pkg::SAMPLE_W
) (
    input  wire logic                clk,      // core clock
    input  wire logic                rst,      // async reset, high
    input  wire logic                clk_en,   // freezes state when low
    input  wire logic [SAMPLE_W-1:0] sample,   // analog level, offset code
    input  wire logic [SAMPLE_W-1:0] ref_top,  // top_reference_level
    input  wire logic [SAMPLE_W-1:0] ref_bot,  // bottom_reference_level
    conv_link_if.device              link      // link to capture logic
);
    typedef enum logic [1:0] {ST_RUN = 2'b01, ST_DOWN = 2'b10} pd_state_t;

    // straight_offset_binary_format quantiser with clamping
    function automatic logic [7:0] quantise(input logic [SAMPLE_W-1:0] v,
                                            input logic [SAMPLE_W-1:0] top,
                                            input logic [SAMPLE_W-1:0] bot);
        logic [SAMPLE_W+8:0] num;
        logic [SAMPLE_W:0]   span;
        logic [SAMPLE_W+8:0] q;
        num  = '0;
        span = '0;
        q    = '0;
        if (v >= top) begin
            quantise = conv_pkg::CODE_MAX;
        end else if (v <= bot || top <= bot) begin
            quantise = conv_pkg::CODE_MIN;
        end else begin
            span = {1'b0, top} - {1'b0, bot};
            num  = {9'h0, v - bot} << 8;
            q    = num / {8'h0, span};
            quantise = (q > 9'(255)) ? conv_pkg::CODE_MAX : q[7:0];
        end
    endfunction : quantise

    logic [2:0] clk_s_q;
    logic [1:0] pd_s_q;
    logic       pd_lvl;
    logic       edge_w;
    pd_state_t  st_q, st_d;
    logic [7:0] pipe_q [conv_pkg::PIPE_DEPTH];
    logic [7:0] pipe_d [conv_pkg::PIPE_DEPTH];
    logic [2:0] inval_q, inval_d;
    logic [7:0] data_q, data_d;
    logic       oe_n_q, oe_n_d;

    assign pd_lvl = pd_s_q[1];
    assign edge_w = clk_s_q[1] & ~clk_s_q[2];

    always_comb begin
        st_d    = st_q;
        pipe_d  = pipe_q;
        inval_d = inval_q;
        data_d  = data_q;
        oe_n_d  = oe_n_q;
        case (st_q)
            ST_RUN: begin
                if (pd_lvl) begin
                    st_d   = ST_DOWN;
                    oe_n_d = 1'b1;
                end else if (edge_w) begin
                    pipe_d[0] = quantise(sample, ref_top, ref_bot);
                    for (int i = 1; i < conv_pkg::PIPE_DEPTH; i++) begin
                        pipe_d[i] = pipe_q[i-1];
                    end
                    // words during recovery are junk
                    if (inval_q != 3'h0) begin
                        inval_d = inval_q - 3'h1;
                        data_d  = ~pipe_q[conv_pkg::PIPE_DEPTH-1];
                    end else begin
                        data_d  = pipe_q[conv_pkg::PIPE_DEPTH-1];
                    end
                    oe_n_d = 1'b0;
                end
            end
            ST_DOWN: begin
                oe_n_d = 1'b1;
                if (!pd_lvl) begin
                    st_d    = ST_RUN;
                    inval_d = conv_pkg::INVALID_CNT;
                end
            end
            default: st_d = ST_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_s_q <= '0;
            pd_s_q  <= '0;
            st_q    <= ST_RUN;
            for (int i = 0; i < conv_pkg::PIPE_DEPTH; i++) begin
                pipe_q[i] <= conv_pkg::CODE_MID;
            end
            inval_q <= conv_pkg::INVALID_CNT;
            data_q  <= '0;
            oe_n_q  <= 1'b1;
        end else if (clk_en) begin
            clk_s_q <= {clk_s_q[1:0], link.conv_clk & ~link.conv_clk_oe_n};
            // undriven pin reads low via pull-down, masked before the sync
            pd_s_q  <= {pd_s_q[0], link.power_down & ~link.power_down_oe_n};
            st_q    <= st_d;
            pipe_q  <= pipe_d;
            inval_q <= inval_d;
            data_q  <= data_d;
            oe_n_q  <= oe_n_d;
        end
    end

    assign link.data      = data_q;
    assign link.data_oe_n = oe_n_q;
endmodule : conv_device
`default_nettype wire

// [hw/conv_capture.sv]
`timescale 1ns/10ps
`default_nettype none
module conv_capture (
    input  wire logic       clk,         // core clock
    input  wire logic       rst,         // async reset, high
    input  wire logic       clk_en,      // freezes state when low
    input  wire logic       pd_req,      // request power-down
    output logic            word_valid,  // one-cycle pulse, word captured
    output logic [7:0]      word,        // captured sample
    conv_link_if.capture    link         // link to converter
);
    logic [3:0] div_q, div_d;
    logic       cclk_q, cclk_d;
    logic       pd_q, pd_d;
    logic       pd_oe_n_q, pd_oe_n_d;
    logic [2:0] skip_q, skip_d;
    logic [7:0] d_s1_q, d_s2_q;
    logic [1:0] z_s_q;
    logic       vld_q, vld_d;
    logic [7:0] word_q, word_d;
    logic       rise_w;

    assign rise_w = (div_q == conv_pkg::CLK_DIV - 4'h1) & ~cclk_q;

    always_comb begin
        div_d  = div_q;
        cclk_d = cclk_q;
        pd_d   = pd_req;
        // line released while idle, the far pull-down holds it low
        pd_oe_n_d = ~pd_req;
        skip_d = skip_q;
        vld_d  = 1'b0;
        word_d = word_q;
        // toggle every CLK_DIV cycles, even duty, within 30MSPS
        if (div_q == conv_pkg::CLK_DIV - 4'h1) begin
            div_d  = 4'h0;
            cclk_d = ~cclk_q;
        end else begin
            div_d = div_q + 4'h1;
        end
        if (pd_q) begin
            // invalid words plus the ones still crossing the data sync
            skip_d = conv_pkg::INVALID_CNT + conv_pkg::LINK_LAG;
        end else if (rise_w) begin
            if (skip_q != 3'h0) begin
                skip_d = skip_q - 3'h1;
            end else if (!z_s_q[1]) begin
                vld_d  = 1'b1;
                word_d = d_s2_q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q  <= '0;
            cclk_q <= 1'b0;
            pd_q   <= 1'b1;
            pd_oe_n_q <= 1'b0;
            skip_q <= conv_pkg::INVALID_CNT + conv_pkg::LINK_LAG;
            d_s1_q <= '0;
            d_s2_q <= '0;
            z_s_q  <= 2'b11;
            vld_q  <= 1'b0;
            word_q <= '0;
        end else if (clk_en) begin
            div_q  <= div_d;
            cclk_q <= cclk_d;
            pd_q   <= pd_d;
            pd_oe_n_q <= pd_oe_n_d;
            skip_q <= skip_d;
            d_s1_q <= link.data;
            d_s2_q <= d_s1_q;
            z_s_q  <= {z_s_q[0], link.data_oe_n};
            vld_q  <= vld_d;
            word_q <= word_d;
        end
    end

    assign link.conv_clk        = cclk_q;
    assign link.conv_clk_oe_n   = 1'b0;
    assign link.power_down      = pd_q;
    assign link.power_down_oe_n = pd_oe_n_q;
    assign word_valid           = vld_q;
    assign word                 = word_q;
endmodule : conv_capture
`default_nettype wire

// [test/conv_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module conv_monitor (
    input  wire logic                        clk,             // core clock
    input  wire logic                        rst,             // async reset, high
    input  wire logic                        clk_en,          // checks paused when low
    input  wire logic                        conv_clk,        // link clock
    input  wire logic                        conv_clk_oe_n,   // link clock enable
    input  wire logic                        power_down,      // power-down line
    input  wire logic                        power_down_oe_n, // power-down enable
    input  wire logic [conv_pkg::DATA_W-1:0] data,            // output word
    input  wire logic                        data_oe_n        // tri-state control
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !clk_en);
    property p_tri; power_down [*4] |-> data_oe_n; endproperty
    property p_enter; $rose(power_down) |-> ##[1:4] data_oe_n; endproperty
    property p_leave; $fell(power_down) |-> ##[1:8] !data_oe_n; endproperty
    property p_wake; $fell(data_oe_n) |-> !power_down; endproperty
    property p_one;
        $changed(data) && !data_oe_n && !$past(data_oe_n) |=> $stable(data) [*3];
    endproperty
    property p_rate; $rose(conv_clk) |=> (!$rose(conv_clk)) [*3]; endproperty
    property p_duty; $rose(conv_clk) |-> conv_clk [*2] ##1 !conv_clk [*2]; endproperty
    property p_driven; power_down |-> !power_down_oe_n && !conv_clk_oe_n; endproperty
    property p_float; $rose(power_down_oe_n) |-> ##[1:10] !data_oe_n; endproperty
    a_tri: assert property (p_tri) else $error("outputs driven in power-down");
    a_enter: assert property (p_enter) else $error("no tri-state on power-down");
    a_leave: assert property (p_leave) else $error("outputs stay off");
    a_wake: assert property (p_wake) else $error("woke while down");
    a_one: assert property (p_one) else $error("word changed twice");
    a_rate: assert property (p_rate) else $error("link clock too fast");
    a_duty: assert property (p_duty) else $error("link clock duty off");
    a_driven: assert property (p_driven) else $error("control line floats");
    a_float: assert property (p_float) else $error("released line not read low");
    c_wake: cover property ($fell(data_oe_n));
    c_sleep: cover property ($rose(data_oe_n));
    c_word: cover property ($changed(data) && !data_oe_n);
endmodule : conv_monitor
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                          clk;
    logic                          rst;
    logic                          pd_req;
    logic                          clk_en;
    int                            exp_q [$];
    logic [conv_pkg::SAMPLE_W-1:0] sample;
    logic                          word_valid;
    logic [7:0]                    word;
    int                            err_count;
    int                            n_tests;
    int                            k;
    integer                        seed;
    conv_link_if link ();
    conv_device conv_device_i (.clk(clk), .rst(rst), .clk_en(clk_en), .sample(sample),
        .ref_top(12'h900), .ref_bot(12'h100), .link(link));
    conv_capture conv_capture_i (.clk(clk), .rst(rst), .clk_en(clk_en), .pd_req(pd_req),
        .word_valid(word_valid), .word(word), .link(link));
    conv_monitor conv_monitor_i (.clk(clk), .rst(rst), .clk_en(clk_en), .conv_clk(link.conv_clk),
        .conv_clk_oe_n(link.conv_clk_oe_n), .power_down(link.power_down),
        .power_down_oe_n(link.power_down_oe_n), .data(link.data), .data_oe_n(link.data_oe_n));
    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // reference coding with top at 900 and bottom at 100
    function automatic logic [7:0] code(input int v);
        if (v >= 'h900) return 8'hff;
        if (v <= 'h100) return 8'h00;
        return 8'((v - 'h100) * 256 / 'h800);
    endfunction : code
    task automatic wait_word();
        k = 0;
        while (word_valid !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        if (word_valid !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t no word captured", $time);
        end
    endtask : wait_word
    task automatic apply(input logic [11:0] v);
        @(posedge clk);
        sample <= v;
        exp_q.push_back(int'(code(int'(v))));
        repeat (40) @(posedge clk);
        @(negedge clk);
        wait_word();
        check(word, 8'(exp_q.pop_front()));
    endtask : apply
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
    initial begin
        rst = 1'b1;
        pd_req = 1'b1;
        clk_en = 1'b1;
        sample = '0;
        seed = 66110;
        err_count = 0;
        n_tests = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        pd_req <= 1'b0;
        apply(12'h500);
        apply(12'h4f8);
        apply(12'h8ff);
        apply(12'h900);
        apply(12'hfff);
        apply(12'h108);
        apply(12'h100);
        apply(12'h000);
        repeat (20) apply(12'($random(seed)));
        @(posedge clk);
        pd_req <= 1'b1;
        sample <= 12'h300;
        repeat (8) @(posedge clk);
        k = 0;
        repeat (40) begin
            @(negedge clk);
            k += int'(word_valid);
            check({7'h00, link.data_oe_n}, 8'h01);
        end
        check(8'(k), 8'h00);
        @(posedge clk);
        pd_req <= 1'b0;
        @(negedge clk);
        wait_word();
        check(word, code('h300));
        k = 0;
        repeat (40) begin
            @(negedge clk);
            k += int'(word_valid);
        end
        check(8'(k), 8'h0a);
        // freeze both ends: no word may move while the enable is low
        @(posedge clk);
        clk_en <= 1'b0;
        k = 0;
        repeat (40) begin
            @(negedge clk);
            k += int'(word_valid);
            check(link.data, code('h300));
        end
        check(8'(k), 8'h00);
        @(posedge clk);
        clk_en <= 1'b1;
        @(negedge clk);
        wait_word();
        check(word, code('h300));
        end_sim();
    end
endmodule : testbench
`default_nettype wire
